// *** common/fetch_pkg.sv ***
package fetch_pkg;

  // Widths of the core datapath
  localparam int unsigned PC_W       = 21;
  localparam int unsigned WORD_W     = 16;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned BANK_W     = 4;
  localparam int unsigned DADDR_W    = 12;

  // Reset values
  localparam logic [PC_W-1:0]   RESET_VECTOR = 21'h000000;
  localparam logic [WORD_W-1:0] NOP_WORD     = 16'h0000;
  localparam logic [DATA_W-1:0] BYTE_RST     = 8'h00;
  localparam logic [BANK_W-1:0] BANK_RST     = 4'h0;

  // Instruction stepping in bytes and second-word marker
  localparam logic [PC_W-1:0]   PC_STEP      = 21'h000002;
  localparam logic [3:0]        SECOND_MARK  = 4'hF;
  localparam int unsigned       LIT_W        = 12;

  // Quadrature phase codes, one-hot
  typedef enum logic [3:0] {
    PH_ONE   = 4'h1,
    PH_TWO   = 4'h2,
    PH_THREE = 4'h4,
    PH_FOUR  = 4'h8
  } phase_e;

  // Decoded control of the word in the execute stage
  typedef enum logic [7:0] {
    OP_PLAIN     = 8'h01,
    OP_JUMP      = 8'h02,
    OP_CALL      = 8'h04,
    OP_BRANCH    = 8'h08,
    OP_RET       = 8'h10,
    OP_RETI      = 8'h20,
    OP_ADD_LOW   = 8'h40,
    OP_TABLE_RD  = 8'h80
  } op_e;

  // Context held by the one-level shadow copies
  typedef struct packed {
    logic [DATA_W-1:0] status;
    logic [DATA_W-1:0] working;
    logic [BANK_W-1:0] bank;
  } context_s;

  // Decoded execute request from the datapath
  typedef struct packed {
    op_e               op;
    logic              fast;
    logic [PC_W-2:0]   target_word;
    logic [10:0]       rel_words;
    logic              two_word;
  } exec_req_s;

  // Data memory access of one instruction cycle
  typedef struct packed {
    logic               rd;
    logic               wr;
    logic [DADDR_W-1:0] addr;
    logic [DATA_W-1:0]  wdata;
  } dmem_req_s;

endpackage

// *** hdl/cpu_fetch_pipeline_fast_stack.sv ***
`timescale 1ns/100ps
// How it works
// - Keep one shadow copy of status, working and bank; load on interrupt vector.
// - Shadow copies have no software access; only hardware loads and fast returns.
// - Fast return-from-interrupt copies all three shadow values back.
// - A nested high-priority interrupt overwrites shadow values saved by low entry.
// - Fast call saves the three values; fast subroutine return restores them.
// - Adding working to counter low byte advances counter by that many bytes.
// - Table reads use a byte pointer and one-byte latch, one byte per transfer.
// - Divide clock by four into four one-hot phases forming one cycle.
// - Counter increments in phase one; fetched word latched in phase four.
// - Operand read in phase two, result written in phase four.
// - Fetch overlaps execute, giving one instruction per cycle.
// - Counter-changing instructions flush the fetched word and take two cycles.
// - Counter steps by two and its low bit always stays zero.
// - Absolute jump and call load their word address into counter bits 20:1.
// - Branch offsets count single-word instructions, not bytes.
// - Second words carry 1111 on top and twelve literal bits.
// - A lone 1111 word executes as no-operation; after its first word it is consumed.
module cpu_fetch_pipeline_fast_stack
  import fetch_pkg::*;
#(
  parameter int unsigned ADDR_W = PC_W
) (
  // Clock and reset
  input  wire logic              clock_in,
  input  wire logic              rst_b_in,
  // Program memory
  output logic [PC_W-1:0]        pmem_addr_out,
  input  wire logic [WORD_W-1:0] pmem_word_in,
  // Decoded execute request and interrupt entry
  input  wire exec_req_s         exec_req_in,
  input  wire logic              irq_vector_in,
  input  wire logic [PC_W-1:0]   irq_addr_in,
  input  wire logic [PC_W-1:0]   ret_addr_in,
  // Live context and its updates from the ALU
  input  wire context_s          ctx_next_in,
  input  wire logic              ctx_we_in,
  output context_s               ctx_out,
  // Table pointer load and program byte read
  input  wire logic              tbl_ptr_we_in,
  input  wire logic [PC_W-1:0]   tbl_ptr_in,
  output logic [PC_W-1:0]        tbl_ptr_out,
  output logic [DATA_W-1:0]      tbl_latch_out,
  // Data memory
  input  wire dmem_req_s         dmem_req_in,
  output logic                   dmem_rd_out,
  output logic                   dmem_wr_out,
  output logic [DADDR_W-1:0]     dmem_addr_out,
  output logic [DATA_W-1:0]      dmem_wdata_out,
  // Pipeline status
  output phase_e                 phase_out,
  output logic [WORD_W-1:0]      instr_out,
  output logic                   exec_valid_out,
  output logic                   lone_second_out,
  output logic [PC_W-1:0]        pc_out
);

  // Only the full 21-bit counter is served; refuse anything else at elaboration
  if (ADDR_W != PC_W) begin : g_width_check
    $error("ADDR_W must equal the 21-bit counter width");
  end

  phase_e            phase_r;
  logic [PC_W-1:0]   pc_r;
  logic [PC_W-1:0]   pc_nxt;
  logic [WORD_W-1:0] ir_r;
  logic              valid_r;
  logic              flush_r;
  logic              second_due_r;
  context_s          ctx_r;
  context_s          shadow_r;
  logic [PC_W-1:0]   tbl_ptr_r;
  logic [DATA_W-1:0] tbl_latch_r;
  logic              redirect;
  logic              is_second;
  logic              tbl_fetch;

  // True when a word carries the second-word marker
  function automatic logic second_word(input logic [WORD_W-1:0] w);
    return w[WORD_W-1 -: 4] == SECOND_MARK;
  endfunction

  // Forces the byte address onto a word boundary
  function automatic logic [PC_W-1:0] align(input logic [PC_W-1:0] a);
    return {a[PC_W-1:1], 1'b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Phase generator

  // One-hot ring; four input clocks make one instruction cycle
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase_r <= PH_ONE;
    end else begin
      case (phase_r)
        PH_ONE:   phase_r <= PH_TWO;
        PH_TWO:   phase_r <= PH_THREE;
        PH_THREE: phase_r <= PH_FOUR;
        PH_FOUR:  phase_r <= PH_ONE;
        default:  phase_r <= PH_ONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Execute-stage qualification

  // A lone second word, or one behind a flush, acts as no-operation
  assign is_second = second_word(ir_r);
  assign redirect  = valid_r && !flush_r && !is_second && (exec_req_in.op != OP_PLAIN)
                     && (exec_req_in.op != OP_TABLE_RD);

  // Next counter value, chosen at the end of the execute cycle
  always_comb begin
    pc_nxt = pc_r;
    case (exec_req_in.op)
      OP_JUMP, OP_CALL:
        pc_nxt = {exec_req_in.target_word, 1'b0};
      OP_BRANCH:
        pc_nxt = align(pc_r + {{(PC_W-12){exec_req_in.rel_words[10]}},
                               exec_req_in.rel_words, 1'b0});
      OP_ADD_LOW:
        pc_nxt = align(pc_r - PC_STEP + {13'h0000, ctx_r.working});
      OP_RET, OP_RETI:
        pc_nxt = align(ret_addr_in);
      default:
        pc_nxt = pc_r;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter

  // Steps by two in phase one; redirects in phase four, low bit pinned to zero
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pc_r <= RESET_VECTOR;
    end else if (phase_r == PH_FOUR && irq_vector_in) begin
      pc_r <= align(irq_addr_in);
    end else if (phase_r == PH_FOUR && redirect) begin
      pc_r <= pc_nxt;
    end else if (phase_r == PH_ONE) begin
      pc_r <= align(pc_r + PC_STEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch and instruction holding register

  // Phase three lends the port to an executing table read
  assign tbl_fetch = (phase_r == PH_THREE) && valid_r && !flush_r && !is_second
                     && (exec_req_in.op == OP_TABLE_RD);

  // The address is the counter before its phase-one step. The fetched word is
  // only latched in phase four, so borrowing phase three costs no cycle.
  assign pmem_addr_out = tbl_fetch ? align(tbl_ptr_r) :
                         (phase_r == PH_ONE) ? pc_r : align(pc_r - PC_STEP);

  // Word latched in phase four; overlaps the execute of the previous word
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ir_r    <= NOP_WORD;
      valid_r <= 1'b0;
      flush_r <= 1'b0;
    end else if (phase_r == PH_FOUR) begin
      ir_r    <= pmem_word_in;
      valid_r <= 1'b1;
      flush_r <= redirect || irq_vector_in;
    end
  end

  // Tracks whether the next word directly follows a two-word opener
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      second_due_r <= 1'b0;
    end else if (phase_r == PH_FOUR) begin
      second_due_r <= valid_r && !flush_r && !is_second && exec_req_in.two_word
                      && !redirect;
    end
  end

  // Flags a marker word reached alone; it does nothing
  assign lone_second_out = valid_r && is_second && !second_due_r;

  ////////////////////////////////////////////////////////////////////////////
  // Context and shadow copies

  // Live registers; a fast return overrides the ALU write of that cycle
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctx_r <= '{status: BYTE_RST, working: BYTE_RST, bank: BANK_RST};
    end else if (phase_r == PH_FOUR && redirect && exec_req_in.fast
                 && (exec_req_in.op == OP_RETI || exec_req_in.op == OP_RET)) begin
      ctx_r <= shadow_r;
    end else if (phase_r == PH_FOUR && ctx_we_in && valid_r && !flush_r && !is_second) begin
      ctx_r <= ctx_next_in;
    end
  end

  // No software path reaches the shadow; every vector reloads it
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      shadow_r <= '{status: BYTE_RST, working: BYTE_RST, bank: BANK_RST};
    end else if (phase_r == PH_FOUR && irq_vector_in) begin
      shadow_r <= ctx_r;
    end else if (phase_r == PH_FOUR && redirect && exec_req_in.fast
                 && exec_req_in.op == OP_CALL) begin
      shadow_r <= ctx_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Table pointer and latch

  // One byte per transfer: odd pointer picks the high byte of the word
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tbl_ptr_r   <= RESET_VECTOR;
      tbl_latch_r <= BYTE_RST;
    end else begin
      if (tbl_ptr_we_in) begin
        tbl_ptr_r <= tbl_ptr_in;
      end
      // The word on the port is the one at the aligned pointer in this phase
      if (tbl_fetch) begin
        tbl_latch_r <= tbl_ptr_r[0] ? pmem_word_in[15:8] : pmem_word_in[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data memory strobes

  // Read only in phase two, write only in phase four, never for a no-op
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      dmem_rd_out    <= 1'b0;
      dmem_wr_out    <= 1'b0;
      dmem_addr_out  <= '0;
      dmem_wdata_out <= BYTE_RST;
    end else begin
      dmem_rd_out    <= (phase_r == PH_ONE) && valid_r && !flush_r && !is_second
                        && dmem_req_in.rd;
      dmem_wr_out    <= (phase_r == PH_THREE) && valid_r && !flush_r && !is_second
                        && dmem_req_in.wr;
      dmem_addr_out  <= dmem_req_in.addr;
      dmem_wdata_out <= dmem_req_in.wdata;
    end
  end

  // Status outputs
  assign phase_out      = phase_r;
  assign instr_out      = ir_r;
  assign exec_valid_out = valid_r && !flush_r && !is_second;
  assign pc_out         = pc_r;
  assign ctx_out        = ctx_r;
  assign tbl_ptr_out    = tbl_ptr_r;
  assign tbl_latch_out  = tbl_latch_r;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_fast_call;
    (phase_r == PH_FOUR) && redirect && exec_req_in.fast && exec_req_in.op == OP_CALL
      && !irq_vector_in;
  endsequence

  // Absolute redirect at the end of an execute cycle; a vector would win instead
  sequence s_abs_redirect;
    (phase_r == PH_FOUR) && redirect && !irq_vector_in
      && (exec_req_in.op == OP_JUMP || exec_req_in.op == OP_CALL);
  endsequence

  AST_PHASE_RING: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    phase_r == PH_ONE |=> phase_r == PH_TWO ##1 phase_r == PH_THREE ##1 phase_r == PH_FOUR)
    else $error("phase ring out of order");

  AST_PC_STEP: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    phase_r == PH_ONE |=> pc_r == align($past(pc_r) + PC_STEP))
    else $error("counter did not step by two");

  AST_PC_EVEN: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    pc_r[0] == 1'b0)
    else $error("counter low bit set");

  AST_SHADOW_IRQ: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (phase_r == PH_FOUR && irq_vector_in) |=> shadow_r == $past(ctx_r))
    else $error("shadow not loaded on vector");

  AST_FAST_CALL: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    s_fast_call |=> shadow_r == $past(ctx_r))
    else $error("fast call did not save context");

  AST_FAST_RETI: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (phase_r == PH_FOUR && redirect && exec_req_in.fast && exec_req_in.op == OP_RETI)
      |=> ctx_r == $past(shadow_r))
    else $error("fast return did not restore context");

  AST_FLUSH: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (phase_r == PH_FOUR && redirect) |=> !exec_valid_out [*4])
    else $error("fetched word not flushed");

  AST_DMEM_WR: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    dmem_wr_out |-> phase_r == PH_FOUR)
    else $error("data write outside phase four");

  AST_DMEM_RD: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    dmem_rd_out |-> phase_r == PH_TWO)
    else $error("data read outside phase two");

  AST_LONE_NOP: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    lone_second_out |-> !exec_valid_out)
    else $error("lone second word executed");

  // A lone marker word must leave counter and context untouched
  AST_LONE_STILL: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (phase_r == PH_FOUR && lone_second_out && !irq_vector_in)
      |=> ctx_r == $past(ctx_r) && pc_r == $past(pc_r))
    else $error("lone second word changed state");

  AST_ABS_TARGET: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    s_abs_redirect |=> pc_r[PC_W-1:1] == $past(exec_req_in.target_word))
    else $error("absolute target not loaded into word bits");

  AST_IR_LATCH: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    phase_r == PH_FOUR |=> ir_r == $past(pmem_word_in))
    else $error("fetched word not latched in phase four");

  // Without a redirect or vector the counter only moves in phase one
  AST_PC_HOLD: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (phase_r == PH_FOUR && !redirect && !irq_vector_in) |=> pc_r == $past(pc_r))
    else $error("counter moved without a redirect");

  // Nothing outside the phase-four hardware events may touch the shadow
  AST_SHADOW_HOLD: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    phase_r != PH_FOUR |=> shadow_r == $past(shadow_r))
    else $error("shadow changed outside a hardware event");

  AST_TBL_HIGH: assert property (@(posedge clock_in) disable iff (!rst_b_in)
    (tbl_fetch && tbl_ptr_r[0]) |=> tbl_latch_r == $past(pmem_word_in[15:8]))
    else $error("odd table pointer did not pick the high byte");

endmodule // cpu_fetch_pipeline_fast_stack

// *** verif/mem_model.sv ***
`timescale 1ns/100ps
// Program and data memory arrays on the far side of the core
module mem_model
  import fetch_pkg::*;
(
  // Clock
  input  wire logic               clock_in,
  // Program memory
  input  wire logic [PC_W-1:0]    pmem_addr_in,
  output logic [WORD_W-1:0]       pmem_word_out,
  // Data memory
  input  wire logic               dmem_wr_in,
  input  wire logic [DADDR_W-1:0] dmem_addr_in,
  input  wire logic [DATA_W-1:0]  dmem_wdata_in
);
  logic [DATA_W-1:0] dmem [0:4095];

  // Two marked second words; every other word carries its own index
  function automatic logic [WORD_W-1:0] word_at(input logic [PC_W-1:0] a);
    if (a[8:1] == 8'h40) return 16'hF123;
    if (a[8:1] == 8'h42) return 16'hF456;
    return {8'h10, a[8:1]};
  endfunction

  // Word-wide array, so the low address bit never selects anything
  assign pmem_word_out = word_at(pmem_addr_in);

  // Destination write lands on the strobe edge
  always_ff @(posedge clock_in) begin
    if (dmem_wr_in) begin
      dmem[dmem_addr_in] <= dmem_wdata_in;
    end
  end
endmodule // mem_model

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
  import fetch_pkg::*;
  localparam exec_req_s NOP_R = '{OP_PLAIN, 1'b0, 20'h0, 11'h0, 1'b0};
  // Design connections, all inputs valued at time zero
  logic               clock_in = 1'b0;
  logic               rst_b_in = 1'b0;
  logic [PC_W-1:0]    pmem_addr_out;
  logic [WORD_W-1:0]  pmem_word_in;
  exec_req_s          exec_req_in = NOP_R;
  logic               irq_vector_in = 1'b0;
  logic [PC_W-1:0]    irq_addr_in = '0;
  logic [PC_W-1:0]    ret_addr_in = '0;
  context_s           ctx_next_in = '0;
  logic               ctx_we_in = 1'b0;
  context_s           ctx_out;
  logic               tbl_ptr_we_in = 1'b0;
  logic [PC_W-1:0]    tbl_ptr_in = '0;
  logic [DATA_W-1:0]  tbl_latch_out;
  dmem_req_s          dmem_req_in = '0;
  logic               dmem_rd_out;
  logic               dmem_wr_out;
  logic [DADDR_W-1:0] dmem_addr_out;
  logic [DATA_W-1:0]  dmem_wdata_out;
  phase_e             phase_out;
  logic [WORD_W-1:0]  instr_out;
  logic               exec_valid_out;
  logic               lone_second_out;
  logic [PC_W-1:0]    pc_out;
  logic [PC_W-1:0]    tbl_ptr_out;
  // Bench state: expected fetch address tracked on our own
  int                 error_cnt = 0;
  int                 comparisons = 0;
  logic [PC_W-1:0]    exp_f = '0;

  // 100 MHz clock
  always #5 clock_in = ~clock_in;

  cpu_fetch_pipeline_fast_stack i_dut (
    .clock_in, .rst_b_in, .pmem_addr_out, .pmem_word_in, .exec_req_in, .irq_vector_in,
    .irq_addr_in, .ret_addr_in, .ctx_next_in, .ctx_we_in, .ctx_out, .tbl_ptr_we_in,
    .tbl_ptr_in, .tbl_ptr_out, .tbl_latch_out, .dmem_req_in, .dmem_rd_out, .dmem_wr_out,
    .dmem_addr_out, .dmem_wdata_out, .phase_out, .instr_out, .exec_valid_out,
    .lone_second_out, .pc_out
  );

  mem_model i_mem (
    .clock_in, .pmem_addr_in(pmem_addr_out), .pmem_word_out(pmem_word_in),
    .dmem_wr_in(dmem_wr_out), .dmem_addr_in(dmem_addr_out), .dmem_wdata_in(dmem_wdata_out)
  );

  //////////////////////////////////////////////////
  // Shared helpers
  function automatic exec_req_s rq(op_e o, logic f, logic [19:0] t, logic [10:0] r, logic w);
    return '{o, f, t, r, w};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Bounded wait; a hang counts as a mismatch and closes the run
  task automatic wait_ph(input phase_e p);
    int n;
    n = 0;
    while (phase_out !== p && n < 8) begin
      @(negedge clock_in);
      n++;
    end
    if (phase_out !== p) begin
      chk("phase wait", p, phase_out);
      end_of_test();
    end
  endtask

  // One instruction cycle: request held from phase one to the phase-four edge
  task automatic run_cyc(input exec_req_s r, input logic [PC_W-1:0] nxt);
    wait_ph(PH_ONE);
    exec_req_in = r;
    wait_ph(PH_FOUR);
    chk("fetch addr", exp_f, pmem_addr_out);
    chk("counter", exp_f + PC_STEP, pc_out);
    @(negedge clock_in);
    chk("instr", i_mem.word_at(exp_f), instr_out);
    exp_f = nxt;
  endtask

  task automatic wr_ctx(input context_s c);
    ctx_next_in = c;
    ctx_we_in = 1'b1;
    run_cyc(NOP_R, exp_f + PC_STEP);
    ctx_we_in = 1'b0;
    chk("ctx", c, ctx_out);
  endtask

  //////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    phase_e ph [4] = '{PH_ONE, PH_TWO, PH_THREE, PH_FOUR};
    rst_b_in = 1'b1;
    for (int i = 0; i < 4; i++) begin
      chk("phase", ph[i], phase_out);
      chk("first fetch", RESET_VECTOR, pmem_addr_out);
      chk("fetch only", 0, exec_valid_out);
      @(negedge clock_in);
    end
    exp_f = RESET_VECTOR + PC_STEP;
    repeat (3) begin
      run_cyc(NOP_R, exp_f + PC_STEP);
      chk("valid", 1, exec_valid_out);
    end
    $display("t_reset done");
  endtask

  // Jump lands on a lone second word, then a proper pair follows
  task automatic t_jump();
    run_cyc(rq(OP_JUMP, 0, 20'h00040, 0, 0), 21'h000080);
    chk("flush", 0, exec_valid_out);
    run_cyc(NOP_R, 21'h000082);
    chk("lone", 1, lone_second_out);
    chk("lone nop", 0, exec_valid_out);
    run_cyc(NOP_R, 21'h000084);
    run_cyc(rq(OP_PLAIN, 0, 0, 0, 1), 21'h000086);
    chk("paired", 0, lone_second_out);
    run_cyc(NOP_R, 21'h000088);
    $display("t_jump done");
  endtask

  // Forward and backward branches, then a computed jump by working
  task automatic t_redir();
    run_cyc(rq(OP_BRANCH, 0, 0, 11'h003, 0), exp_f + 21'h000008);
    chk("flush", 0, exec_valid_out);
    run_cyc(NOP_R, exp_f + PC_STEP);
    run_cyc(rq(OP_BRANCH, 0, 0, 11'h7FE, 0), exp_f - PC_STEP);
    run_cyc(NOP_R, exp_f + PC_STEP);
    wr_ctx(20'h00060);
    run_cyc(rq(OP_ADD_LOW, 0, 0, 0, 0), exp_f + 21'h000006);
    run_cyc(NOP_R, exp_f + PC_STEP);
    $display("t_redir done");
  endtask

  // Nested interrupt overwrites the first save; fast return restores the nested save
  task automatic t_shadow();
    wr_ctx(20'hA1B2C);
    irq_vector_in = 1'b1;
    irq_addr_in = 21'h000100;
    run_cyc(NOP_R, 21'h000100);
    irq_vector_in = 1'b0;
    run_cyc(NOP_R, 21'h000102);
    wr_ctx(20'h3C4D5);
    irq_vector_in = 1'b1;
    irq_addr_in = 21'h000140;
    run_cyc(NOP_R, 21'h000140);
    irq_vector_in = 1'b0;
    run_cyc(NOP_R, 21'h000142);
    wr_ctx(20'h5E6F7);
    ret_addr_in = 21'h000020;
    run_cyc(rq(OP_RETI, 1, 0, 0, 0), 21'h000020);
    chk("reti ctx", 20'h3C4D5, ctx_out);
    run_cyc(NOP_R, 21'h000022);
    $display("t_shadow done");
  endtask

  task automatic t_fast();
    wr_ctx(20'h12345);
    run_cyc(rq(OP_CALL, 1, 20'h00030, 0, 0), 21'h000060);
    run_cyc(NOP_R, 21'h000062);
    wr_ctx(20'h6789A);
    ret_addr_in = 21'h000010;
    run_cyc(rq(OP_RET, 0, 0, 0, 0), 21'h000010);
    chk("plain ret ctx", 20'h6789A, ctx_out);
    run_cyc(NOP_R, 21'h000012);
    ret_addr_in = 21'h000030;
    run_cyc(rq(OP_RET, 1, 0, 0, 0), 21'h000030);
    chk("fast ret ctx", 20'h12345, ctx_out);
    run_cyc(NOP_R, 21'h000032);
    $display("t_fast done");
  endtask

  task automatic rd_tbl(input logic [PC_W-1:0] p, input logic [7:0] e);
    tbl_ptr_in = p;
    tbl_ptr_we_in = 1'b1;
    run_cyc(NOP_R, exp_f + PC_STEP);
    tbl_ptr_we_in = 1'b0;
    chk("table pointer", p, tbl_ptr_out);
    run_cyc(rq(OP_TABLE_RD, 0, 0, 0, 0), exp_f + PC_STEP);
    chk("table byte", e, tbl_latch_out);
  endtask

  task automatic t_table();
    rd_tbl(21'h000085, 8'hF4);
    rd_tbl(21'h000084, 8'h56);
    $display("t_table done");
  endtask

  // Strobes walked phase by phase through one execute cycle
  task automatic t_dmem();
    dmem_req_in = '{1'b1, 1'b1, 12'h123, 8'h5A};
    repeat (4) begin
      @(negedge clock_in);
      chk("rd strobe", phase_out == PH_TWO, dmem_rd_out);
      chk("wr strobe", phase_out == PH_FOUR, dmem_wr_out);
    end
    dmem_req_in = '0;
    chk("dmem byte", 8'h5A, i_mem.dmem[12'h123]);
    exp_f = exp_f + PC_STEP;
    $display("t_dmem done");
  endtask

  //////////////////////////////////////////////////
  // Main sequence: reset held for two clock periods
  initial begin
    repeat (2) @(negedge clock_in);
    t_reset();
    t_jump();
    t_redir();
    t_shadow();
    t_fast();
    t_table();
    t_dmem();
    end_of_test();
  end
endmodule // tb_top
